// [shared/mac_backoff_pkg.sv]
/*
  Shared constants for the transmit retry, collision back-off and receive
  pad-strip block: register offsets, field positions, reset values and limits.
  Assumes a 32-bit APB register bus and byte-wide receive data.
*/
package mac_backoff_pkg;
  // ****************************************
  // Register map.
  // ****************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h08;
  localparam logic [7:0] TX_STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] LFSR_OFFSET = 8'h10;

  // ****************************************
  // Field positions and reset values.
  // ****************************************
  localparam int SINGLE_ATTEMPT_BIT = 10;
  localparam int PAD_STRIP_BIT = 8;
  localparam int BACKOFF_LIMIT_LSB = 6;
  localparam int IRQ_TX_OK_BIT = 0;
  localparam int IRQ_RETRY_ERR_BIT = 1;
  localparam int IRQ_RX_STRIP_BIT = 2;
  localparam int TX_STATUS_ERR_BIT = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [19:0] LFSR_SEED = 20'h00001;

  // ****************************************
  // Limits.
  // ****************************************
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [3:0] BACKOFF_K_MAX = 4'ha;
  localparam logic [3:0] LIMIT_BITS_00 = 4'ha;
  localparam logic [3:0] LIMIT_BITS_01 = 4'h8;
  localparam logic [3:0] LIMIT_BITS_10 = 4'h4;
  localparam logic [3:0] LIMIT_BITS_11 = 4'h1;
  localparam logic [15:0] MIN_LENGTH_FIELD = 16'h002e;
  localparam logic [10:0] LEN_HI_INDEX = 11'h00c;
  localparam logic [10:0] LEN_LO_INDEX = 11'h00d;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ATTEMPT = 2'b01,
    TX_BACKOFF = 2'b11,
    TX_REPORT = 2'b10
  } tx_state_e;
endpackage

// [tb/medium_model.sv]
/*
  Medium model: answers each attempt with a collision or a clean end, and
  makes the slot tick. Assumes the transmit ports of the retry block.
*/
`timescale 1ns/1ps
module medium_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tx_attempt_start,
  input wire logic reload,
  input wire logic [4:0] coll_budget,
  output logic tx_collision,
  output logic tx_attempt_ok,
  output logic slot_tick
);
  logic [4:0] used;
  logic [1:0] ph;
  logic [1:0] dly;
  logic busy;
  // The reply delay follows the collision count, so prompt and slow replies both occur.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {used, ph, dly, busy, tx_collision, tx_attempt_ok, slot_tick} <= '0;
    end else begin
      tx_collision <= 1'h0;
      tx_attempt_ok <= 1'h0;
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      slot_tick <= (ph == 2'h2);
      if (reload) begin
        used <= 5'h00;
      end
      if (tx_attempt_start) begin
        busy <= 1'h1;
        dly <= used[1:0];
      end else if (busy && dly != 2'h0) begin
        dly <= dly - 2'h1;
      end else if (busy) begin
        busy <= 1'h0;
        if (used < coll_budget) begin
          tx_collision <= 1'h1;
          used <= used + 5'h01;
        end else begin
          tx_attempt_ok <= 1'h1;
        end
      end
    end
  end
endmodule

// [tb/tb_top.sv]
/*
  Self-checking bench of the retry, back-off and pad-strip block.
  Assumes the medium model as far side and an APB master in the bench.
*/
`timescale 1ns/1ps
module tb_top;
  import mac_backoff_pkg::*;
  // ****************************************
  // Signals and parts.
  // ****************************************
  localparam logic [3:0] LB [4] = '{LIMIT_BITS_00, LIMIT_BITS_01, LIMIT_BITS_10, LIMIT_BITS_11};
  localparam int BUD [4] = '{11, 9, 6, 16};
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
  logic [7:0] paddr = 0, rx_in_data = 0, rx_out_data;
  logic [31:0] pwdata = 0, prdata, rd, pv;
  logic tx_pending = 0, slot_tick, tx_collision, tx_attempt_ok, tx_attempt_start;
  logic tx_status_valid, tx_status_retry_error, reload = 0, strip = 0;
  logic rx_in_valid = 0, rx_in_last = 0, rx_out_valid, rx_out_last, in_bo = 0;
  logic [4:0] tx_status_attempts, budget = 0;
  int n_fail = 0, checks_done = 0, seed = 32'hc827, starts = 0, ticks, ebits, lim = 0, k, l;
  logic [8:0] exp_q[$];
  mac_retry_backoff mac_retry_backoff_i (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .tx_pending, .slot_tick, .tx_collision,
    .tx_attempt_ok, .tx_attempt_start, .tx_status_valid, .tx_status_retry_error,
    .tx_status_attempts, .rx_in_valid, .rx_in_data, .rx_in_last, .rx_out_valid,
    .rx_out_data, .rx_out_last);
  medium_model medium_model_i (.mclk, .rst_n, .tx_attempt_start, .reload,
    .coll_budget(budget), .tx_collision, .tx_attempt_ok, .slot_tick);
  always #12.5 mclk = ~mclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // ****************************************
  // Monitor: back-off length and delivered bytes.
  // ****************************************
  always @(negedge mclk) begin
    if (tx_attempt_start === 1'h1) begin
      if (in_bo) chk(ticks < (1 << ebits), 1);
      in_bo = 0;
      starts++;
    end else if (slot_tick && in_bo) ticks++;
    if (tx_collision) begin
      in_bo = 1;
      ticks = 0;
      ebits = starts > BACKOFF_K_MAX ? BACKOFF_K_MAX : starts;
      if (ebits > LB[lim]) ebits = LB[lim];
    end
    // A collision that ends the frame opens no back-off to be measured.
    if (tx_status_valid === 1'h1) in_bo = 0;
    if (rx_out_valid === 1'h1) chk({rx_out_last, rx_out_data}, exp_q.pop_front());
  end
  task frame(input int b, input logic e, input int att);
    int i;
    @(posedge mclk);
    reload <= 1;
    budget <= b[4:0];
    tx_pending <= 1;
    starts = 0;
    @(posedge mclk);
    reload <= 0;
    while (tx_status_valid !== 1'h1) @(negedge mclk);
    chk({tx_status_retry_error, tx_status_attempts}, {e, att[4:0]});
    chk(starts, att);
    @(posedge mclk);
    tx_pending <= 0;
    apb(0, TX_STATUS_OFFSET, 0);
    chk({rd[8], rd[4:0]}, {e, att[4:0]});
  endtask
  task rxf(input int len);
    int i, n;
    logic [7:0] b;
    n = (14 + len < 60 ? 60 : 14 + len) + 4;
    for (i = 0; i < n; i++) begin
      b = (i == 12) ? 8'h00 : (i == 13) ? len[7:0] : 8'($random(seed));
      if (!(strip && len < 46 && i > 13 + len))
        exp_q.push_back({(strip && len < 46) ? i == 13 + len : i == n - 1, b});
      @(posedge mclk);
      rx_in_valid <= 1;
      rx_in_data <= b;
      rx_in_last <= (i == n - 1);
    end
    @(posedge mclk);
    rx_in_valid <= 0;
    rx_in_last <= 0;
    repeat (2) @(negedge mclk);
    chk(exp_q.size(), 0);
  endtask
  // ****************************************
  // Main sequence and watchdog.
  // ****************************************
  initial begin
    #2250000;
    n_fail++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    apb(0, CTRL_OFFSET, 0);
    chk(rd, CTRL_RESET);
    apb(0, IRQ_MASK_OFFSET, 0);
    chk(rd[2:0], IRQ_MASK_RESET);
    apb(1, 8'h14, 32'hffffffff);
    chk(err, 1);
    chk(rd, 0);
    apb(0, LFSR_OFFSET, 0);
    pv = rd;
    apb(0, LFSR_OFFSET, 0);
    chk(rd[19:0] != pv[19:0] && rd[31:20] == 0, 1);
    apb(1, CTRL_OFFSET, 32'h400);
    frame(3, 1, 1);
    for (l = 0; l < 6; l++) begin
      lim = l < 4 ? l : $unsigned($random(seed)) % 4;
      k = l < 4 ? BUD[l] : $unsigned($random(seed)) % 16;
      apb(1, CTRL_OFFSET, lim << BACKOFF_LIMIT_LSB);
      frame(k, k == 16, k == 16 ? 16 : k + 1);
    end
    apb(0, IRQ_STATUS_OFFSET, 0);
    chk({irq, rd[1:0]}, 3'h3);
    apb(1, IRQ_MASK_OFFSET, 32'h2);
    repeat (2) @(negedge mclk);
    chk(irq, 1);
    apb(1, IRQ_STATUS_OFFSET, 32'h2);
    repeat (2) @(negedge mclk);
    chk(irq, 0);
    apb(1, CTRL_OFFSET, 32'h100);
    strip = 1;
    rxf(0);
    rxf(45);
    rxf(46);
    rxf($unsigned($random(seed)) % 100);
    apb(0, IRQ_STATUS_OFFSET, 0);
    chk(rd[2:1], 2'h2);
    apb(1, CTRL_OFFSET, 0);
    strip = 0;
    rxf(10);
    give_verdict;
  end
endmodule

// [verilog/backoff_lfsr.sv]
/*
  Free-running 20-bit maximal-length shift register used as the random source.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module backoff_lfsr
  import mac_backoff_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  output logic [19:0] lfsr
);
  typedef struct packed {
    logic [19:0] value;
  } lfsr_s;

  lfsr_s s;
  lfsr_s next_s;

  // It steps every cycle so that draws at different collisions stay apart.
  always_comb begin
    next_s = s;
    next_s.value = {s.value[18:0], s.value[19] ^ s.value[16]}; // R9 R13
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{value: LFSR_SEED};
    end else begin
      s <= next_s;
    end
  end

  assign lfsr = s.value;

  // The first step after reset comes one edge late, so the check waits a cycle.
  chk_lfsr_moves: assert property (@(posedge mclk) disable iff (!rst_n) // R13
    $past(rst_n) |-> lfsr != $past(lfsr) && lfsr != 20'h00000)
    else $error("lfsr stalled");
endmodule

// [verilog/mac_retry_backoff.sv]
/*
  Transmit retry control with random collision back-off, and receive pad and
  FCS stripping, behind an APB register slave with one interrupt output.
  Assumes a slot-time enable pulse from outside, attempt outcome pulses from
  the medium side and an unstalled byte stream on the receive side.
*/
// Chosen here: the APB interface to the registers and the address map.
// Behaviour
// R1: With single-attempt set, each frame gets exactly one attempt and no retransmission.
// R2: In single-attempt mode a collision drops the frame, moves on and reports a retry error.
// R3: With single-attempt clear, a frame gets up to 16 attempts before a retry error.
// R4: With stripping on, a frame with length field below 46 loses its pad and FCS.
// R5: With stripping on, a frame with length field 46 or more passes whole with FCS.
// R6: With stripping off, every frame passes unmodified.
// R7: After a collision the retry waits r slot times, r below two to the power K.
// R8: K is the smaller of the frame's retry count and ten.
// R9: The random value comes from a 20-bit linear feedback shift register.
// R10: The low K bits of the shift register count down once per slot time to zero.
// R11: The two-bit back-off limit at bits 7-6 caps the bits used; 00 selects 10.
// R12: Limit codes 01, 10 and 11 cap the bits used at 8, 4 and 1.
// R13: The shift register steps every clock regardless of transmit activity.
`timescale 1ns/1ps
module mac_retry_backoff
  import mac_backoff_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic tx_pending,
  input wire logic slot_tick,
  input wire logic tx_collision,
  input wire logic tx_attempt_ok,
  output logic tx_attempt_start,
  output logic tx_status_valid,
  output logic tx_status_retry_error,
  output logic [4:0] tx_status_attempts,
  input wire logic rx_in_valid,
  input wire logic [7:0] rx_in_data,
  input wire logic rx_in_last,
  output logic rx_out_valid,
  output logic [7:0] rx_out_data,
  output logic rx_out_last
);
  // ****************************************
  // Helpers.
  // ****************************************
  function automatic logic [3:0] limit_bits(input logic [1:0] code);
    case (code)
      2'b00: limit_bits = LIMIT_BITS_00; // R11
      2'b01: limit_bits = LIMIT_BITS_01; // R12
      2'b10: limit_bits = LIMIT_BITS_10; // R12
      default: limit_bits = LIMIT_BITS_11; // R12
    endcase
  endfunction

  function automatic logic [3:0] min4(input logic [3:0] a, input logic [3:0] b);
    min4 = (a < b) ? a : b;
  endfunction

  function automatic logic [9:0] low_mask(input logic [3:0] n);
    logic [10:0] t;
    t = (11'h001 << n) - 11'h001;
    low_mask = t[9:0];
  endfunction

  // ****************************************
  // State.
  // ****************************************
  typedef struct packed {
    tx_state_e state;
    logic single_attempt_select;
    logic rx_pad_strip_enable;
    logic [1:0] backoff_bit_limit;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [4:0] attempts;
    logic [9:0] backoff_cnt;
    logic tx_start;
    logic status_valid;
    logic status_err;
    logic [4:0] status_attempts;
    logic [31:0] rdata;
    logic [10:0] rx_idx;
    logic [7:0] rx_len_hi;
    logic rx_strip;
    logic [6:0] rx_end;
    logic rx_drop;
    logic out_valid;
    logic [7:0] out_data;
    logic out_last;
  } core_s;

  core_s s;
  core_s next_s;
  logic [19:0] lfsr;
  logic [3:0] k_bits;
  logic [3:0] use_bits;
  logic [9:0] draw;
  logic wr_en;
  logic mapped;
  logic [15:0] len_field;
  logic strip_now;
  logic [6:0] end_now;
  logic rx_last_now;
  logic [2:0] irq_set;

  backoff_lfsr rng ( // R9
    .mclk(mclk),
    .rst_n(rst_n),
    .lfsr(lfsr)
  );

  // K follows the attempt count; the limit field can only narrow it further.
  assign k_bits = min4({3'h0, s.attempts[4]} | s.attempts[3:0] & {4{~s.attempts[4]}},
    BACKOFF_K_MAX); // R8
  assign use_bits = min4(k_bits, limit_bits(s.backoff_bit_limit)); // R11 R12
  assign draw = lfsr[9:0] & low_mask(use_bits); // R7 R10

  assign mapped = paddr == CTRL_OFFSET || paddr == IRQ_STATUS_OFFSET ||
    paddr == IRQ_MASK_OFFSET || paddr == TX_STATUS_OFFSET || paddr == LFSR_OFFSET;
  assign wr_en = psel && penable && pwrite && mapped;
  assign len_field = {s.rx_len_hi, rx_in_data};

  always_comb begin
    strip_now = s.rx_strip;
    end_now = s.rx_end;
    if (s.rx_idx == LEN_LO_INDEX) begin
      strip_now = s.rx_pad_strip_enable && len_field < MIN_LENGTH_FIELD; // R4 R5 R6
      end_now = 7'h0d + {1'b0, rx_in_data[5:0]};
    end
    rx_last_now = rx_in_last || (strip_now && s.rx_idx == {4'h0, end_now}); // R4
  end

  // ****************************************
  // Next state.
  // ****************************************
  always_comb begin
    next_s = s;
    irq_set = 3'h0;
    next_s.tx_start = 1'b0;
    next_s.status_valid = 1'b0;
    next_s.out_valid = 1'b0;
    next_s.out_last = 1'b0;

    case (s.state)
      TX_IDLE: begin
        if (tx_pending) begin
          next_s.tx_start = 1'b1;
          next_s.attempts = 5'h01;
          next_s.state = TX_ATTEMPT;
        end
      end
      TX_ATTEMPT: begin
        if (tx_collision) begin
          if (s.single_attempt_select || s.attempts == MAX_ATTEMPTS) begin // R1 R2 R3
            next_s.status_err = 1'b1;
            next_s.status_attempts = s.attempts;
            next_s.status_valid = 1'b1;
            irq_set[IRQ_RETRY_ERR_BIT] = 1'b1;
            next_s.state = TX_REPORT;
          end else if (draw == 10'h000) begin
            next_s.tx_start = 1'b1;
            next_s.attempts = s.attempts + 5'h01;
          end else begin
            next_s.backoff_cnt = draw; // R10
            next_s.state = TX_BACKOFF;
          end
        end else if (tx_attempt_ok) begin
          next_s.status_err = 1'b0;
          next_s.status_attempts = s.attempts;
          next_s.status_valid = 1'b1;
          irq_set[IRQ_TX_OK_BIT] = 1'b1;
          next_s.state = TX_REPORT;
        end
      end
      TX_BACKOFF: begin
        if (slot_tick) begin
          next_s.backoff_cnt = s.backoff_cnt - 10'h001; // R10
          if (s.backoff_cnt == 10'h001) begin
            next_s.tx_start = 1'b1;
            next_s.attempts = s.attempts + 5'h01;
            next_s.state = TX_ATTEMPT;
          end
        end
      end
      TX_REPORT: begin
        // One idle cycle lets the queue drop its request after the status pulse.
        next_s.state = TX_IDLE; // R2
      end
      default: begin
        next_s.state = TX_IDLE;
      end
    endcase

    if (rx_in_valid) begin
      if (s.rx_idx == LEN_HI_INDEX) begin
        next_s.rx_len_hi = rx_in_data;
      end
      if (s.rx_idx == LEN_LO_INDEX) begin
        next_s.rx_strip = strip_now;
        next_s.rx_end = end_now;
      end
      if (!s.rx_drop) begin
        next_s.out_valid = 1'b1; // R5 R6
        next_s.out_data = rx_in_data;
        next_s.out_last = rx_last_now;
        if (rx_last_now && !rx_in_last) begin
          next_s.rx_drop = 1'b1; // R4
        end
      end
      if (s.rx_idx != 11'h7ff) begin
        next_s.rx_idx = s.rx_idx + 11'h001;
      end
      if (rx_in_last) begin
        irq_set[IRQ_RX_STRIP_BIT] = strip_now;
        next_s.rx_idx = 11'h000;
        next_s.rx_drop = 1'b0;
        next_s.rx_strip = 1'b0;
      end
    end

    // ****************************************
    // Register access.
    // ****************************************
    if (psel && !penable) begin
      case (paddr)
        CTRL_OFFSET: next_s.rdata = {21'h0, s.single_attempt_select, 1'b0,
          s.rx_pad_strip_enable, s.backoff_bit_limit, 6'h00};
        IRQ_STATUS_OFFSET: next_s.rdata = {29'h0, s.irq_status};
        IRQ_MASK_OFFSET: next_s.rdata = {29'h0, s.irq_mask};
        TX_STATUS_OFFSET: next_s.rdata = {23'h0, s.status_err, 3'h0, s.status_attempts};
        LFSR_OFFSET: next_s.rdata = {12'h000, lfsr};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    // Status bits set by an event in the clearing cycle stay set.
    next_s.irq_status = s.irq_status | irq_set;
    if (wr_en) begin
      case (paddr)
        CTRL_OFFSET: begin
          next_s.single_attempt_select = pwdata[SINGLE_ATTEMPT_BIT];
          next_s.rx_pad_strip_enable = pwdata[PAD_STRIP_BIT];
          next_s.backoff_bit_limit = pwdata[BACKOFF_LIMIT_LSB +: 2];
        end
        IRQ_STATUS_OFFSET: next_s.irq_status = (s.irq_status & ~pwdata[2:0]) | irq_set;
        IRQ_MASK_OFFSET: next_s.irq_mask = pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.state <= TX_IDLE;
      s.single_attempt_select <= CTRL_RESET[SINGLE_ATTEMPT_BIT];
      s.rx_pad_strip_enable <= CTRL_RESET[PAD_STRIP_BIT];
      s.backoff_bit_limit <= CTRL_RESET[BACKOFF_LIMIT_LSB +: 2];
      s.irq_mask <= IRQ_MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s.rdata;
  assign irq = |(s.irq_status & s.irq_mask);
  assign tx_attempt_start = s.tx_start;
  assign tx_status_valid = s.status_valid;
  assign tx_status_retry_error = s.status_err;
  assign tx_status_attempts = s.status_attempts;
  assign rx_out_valid = s.out_valid;
  assign rx_out_data = s.out_data;
  assign rx_out_last = s.out_last;

  // ****************************************
  // Checks.
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence collide_s;
    s.state == TX_ATTEMPT && tx_collision;
  endsequence

  sequence wait_done_s;
    s.state == TX_BACKOFF && slot_tick && s.backoff_cnt == 10'h001;
  endsequence

  chk_single_one_try: assert property (collide_s and s.single_attempt_select // R1
    |=> !tx_attempt_start && s.state == TX_REPORT) else $error("single retried");
  chk_single_abandon: assert property (collide_s and s.single_attempt_select // R2
    |=> tx_status_valid && tx_status_retry_error ##1 s.state == TX_IDLE)
    else $error("no abandon");
  chk_attempt_cap: assert property (tx_status_valid && tx_status_retry_error // R3
    && !$past(s.single_attempt_select) |-> tx_status_attempts == 5'h10)
    else $error("bad attempt cap");
  chk_attempt_bound: assert property (tx_attempt_start |-> s.attempts <= 5'h10) // R3
    else $error("too many attempts");
  chk_backoff_range: assert property (s.state == TX_BACKOFF && $changed(s.state) // R7
    |-> s.backoff_cnt < (11'h001 << $past(k_bits))) else $error("r out of range");
  chk_k_exponent: assert property (s.state == TX_ATTEMPT |-> k_bits <= 4'ha && // R8
    (s.attempts > 5'h0a || k_bits == s.attempts[3:0])) else $error("bad K");
  chk_limit_bits: assert property (s.state == TX_ATTEMPT |-> use_bits <= k_bits && // R11 R12
    use_bits <= limit_bits(s.backoff_bit_limit)) else $error("bad limit");
  chk_backoff_retry: assert property (wait_done_s |=> tx_attempt_start && // R10
    s.state == TX_ATTEMPT) else $error("no retry after wait");
  chk_pad_dropped: assert property (s.rx_drop && $past(s.rx_drop) |-> !rx_out_valid) // R4
    else $error("pad leaked");
  chk_pass_whole: assert property (rx_in_valid && !s.rx_drop && !s.rx_strip && // R5 R6
    s.rx_idx > LEN_LO_INDEX |=> rx_out_valid && rx_out_data == $past(rx_in_data) &&
    rx_out_last == $past(rx_in_last)) else $error("frame altered");
endmodule
